// File: fdsec_regs.svh
// Register indices, field positions and reset values of the FD status and error block.
`ifndef FDSEC_REGS_SVH
`define FDSEC_REGS_SVH

`define FDSEC_IDX_FD_STATUS 6'h25
`define FDSEC_IDX_DP_ERRCNT 6'h26
`define FDSEC_IDX_MODE 6'h30
`define FDSEC_IDX_FD_CONTROL 6'h31
`define FDSEC_IDX_INT_STATUS 6'h32
`define FDSEC_IDX_INT_ENABLE 6'h33
`define FDSEC_IDX_INT_CLEAR 6'h34

`define FDSEC_STATE_MSB 7
`define FDSEC_STATE_LSB 6
`define FDSEC_BIT_PEE 4
`define FDSEC_BIT_STUFF 3
`define FDSEC_BIT_FORM 2
`define FDSEC_BIT_CRC 1
`define FDSEC_BIT_BITERR 0
`define FDSEC_BIT_DPINC 5
`define FDSEC_NUM_FLAGS 5
`define FDSEC_NUM_INTS 6

`define FDSEC_BIT_RSTMODE 0
`define FDSEC_BIT_FDEN 0

`define FDSEC_RST_FD_STATUS 8'h00
`define FDSEC_RST_DP_ERRCNT 8'h00
`define FDSEC_RST_MODE 1'b1
`define FDSEC_RST_FDEN 1'b0
`define FDSEC_CNT_MAX 8'hff

`endif

// File: fdsec_pkg.sv
// Types shared by the FD status and error block.
package fdsec_pkg;

  typedef enum logic [1:0] {
    FDSEC_ST_INTEGRATING = 2'b00,
    FDSEC_ST_IDLE = 2'b01,
    FDSEC_ST_RECEIVER = 2'b10,
    FDSEC_ST_TRANSMITTER = 2'b11
  } fdsec_opstate_e;

  typedef enum logic {
    FDSEC_BUS_WAIT = 1'b0,
    FDSEC_BUS_ACK = 1'b1
  } fdsec_bus_e;

endpackage

// File: fdsec_dperr_cnt.sv
// Saturating eight-bit data-phase error counter.
`timescale 1ns/10ps
`default_nettype none
`include "fdsec_regs.svh"

module fdsec_dperr_cnt (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic inc,
  output logic [7:0] count
);

  logic [7:0] count_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_ff <= `FDSEC_RST_DP_ERRCNT;
    end else if (clr) begin
      count_ff <= `FDSEC_RST_DP_ERRCNT;
    end else if (inc && (count_ff != `FDSEC_CNT_MAX)) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  assign count = count_ff;

endmodule
`default_nettype wire

// File: fdsec_top.sv
// FD protocol status flags, data-phase error count and their Avalon-MM register slave.
`timescale 1ns/10ps
`default_nettype none
`include "fdsec_regs.svh"

// Function
// - Report protocol operating state in two bits: integrating, idle, receiver, transmitter.
// - Set protocol exception flag on recessive reserved bit, only while FD enabled.
// - Set stuff error flag on data-phase stuffing violation in switched-rate FD frames.
// - Set CRC error flag when computed and received CRC differ, FD mode only.
// - Set bit error flag when sent and monitored bit differ, FD mode only.
// - Count each data-phase error of transmitter or receiver in eight bits, FD mode only.
// - The error counter stops at 255 and never wraps.
// - Reset mode clears the data-phase error counter to zero.
// - FD enable selects classic or FD format and changes only in reset mode.
module fdsec_top
  import fdsec_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] op_state,
  input wire logic evt_res_recessive,
  input wire logic evt_stuff_err,
  input wire logic frame_brs,
  input wire logic evt_form_err,
  input wire logic evt_crc_err,
  input wire logic evt_bit_err,
  input wire logic evt_dp_err,
  output logic fd_enable,
  output logic reset_mode,
  output logic irq
);

  fdsec_bus_e bus_state_ff;
  fdsec_bus_e nxt_bus_state;
  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic reset_mode_ff;
  logic fd_enable_ff;
  logic [1:0] op_state_ff;
  logic [`FDSEC_NUM_FLAGS-1:0] flags_ff;
  logic [`FDSEC_NUM_INTS-1:0] int_status_ff;
  logic [`FDSEC_NUM_INTS-1:0] int_enable_ff;
  logic irq_ff;
  logic [7:0] dp_count;
  logic req;
  logic wr_accept;
  logic addr_ok;
  logic [5:0] idx;
  logic fd_active;
  logic dp_inc;
  logic [`FDSEC_NUM_FLAGS-1:0] flag_evt;
  logic [`FDSEC_NUM_INTS-1:0] int_evt;
  logic [`FDSEC_NUM_INTS-1:0] int_clr;
  logic [7:0] status_byte;

  assign req = avs_read || avs_write;
  assign idx = avs_address[7:2];
  assign addr_ok = (avs_address[1:0] == 2'b00);
  // A write takes effect only at the edge where waitrequest is seen low.
  assign wr_accept = avs_write && (bus_state_ff == FDSEC_BUS_ACK) && avs_byteenable[0] &&
                     addr_ok;

  // Flags are only set while FD frames are enabled and the controller is running.
  assign fd_active = fd_enable_ff && !reset_mode_ff;
  assign flag_evt[`FDSEC_BIT_PEE] = evt_res_recessive;
  assign flag_evt[`FDSEC_BIT_STUFF] = evt_stuff_err && frame_brs;
  assign flag_evt[`FDSEC_BIT_FORM] = evt_form_err;
  assign flag_evt[`FDSEC_BIT_CRC] = evt_crc_err;
  assign flag_evt[`FDSEC_BIT_BITERR] = evt_bit_err;
  assign dp_inc = fd_active && evt_dp_err;

  assign status_byte = {op_state_ff, 1'b0, flags_ff};

  // Bus handshake: one wait cycle, then a single acknowledge cycle.
  always_comb begin
    nxt_bus_state = bus_state_ff;
    unique case (bus_state_ff)
      FDSEC_BUS_WAIT: begin
        if (req) begin
          nxt_bus_state = FDSEC_BUS_ACK;
        end
      end
      FDSEC_BUS_ACK: begin
        nxt_bus_state = FDSEC_BUS_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_state_ff <= FDSEC_BUS_WAIT;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // Waitrequest has its own flop so that the bus never sees decode glitches.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest_ff <= 1'b1;
    end else begin
      waitrequest_ff <= (nxt_bus_state != FDSEC_BUS_ACK);
    end
  end

  always_comb begin
    nxt_readdata = 32'h0000_0000;
    if (addr_ok) begin
      unique case (idx)
        `FDSEC_IDX_FD_STATUS: nxt_readdata[7:0] = status_byte;
        `FDSEC_IDX_DP_ERRCNT: nxt_readdata[7:0] = dp_count;
        `FDSEC_IDX_MODE: nxt_readdata[`FDSEC_BIT_RSTMODE] = reset_mode_ff;
        `FDSEC_IDX_FD_CONTROL: nxt_readdata[`FDSEC_BIT_FDEN] = fd_enable_ff;
        `FDSEC_IDX_INT_STATUS: nxt_readdata[`FDSEC_NUM_INTS-1:0] = int_status_ff;
        `FDSEC_IDX_INT_ENABLE: nxt_readdata[`FDSEC_NUM_INTS-1:0] = int_enable_ff;
        default: nxt_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata_ff <= 32'h0000_0000;
    end else if (avs_read && (bus_state_ff == FDSEC_BUS_WAIT)) begin
      readdata_ff <= nxt_readdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reset_mode_ff <= `FDSEC_RST_MODE;
    end else if (wr_accept && (idx == `FDSEC_IDX_MODE)) begin
      reset_mode_ff <= avs_writedata[`FDSEC_BIT_RSTMODE];
    end
  end

  // The format may only change while the protocol engine is held in reset mode.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fd_enable_ff <= `FDSEC_RST_FDEN;
    end else if (wr_accept && (idx == `FDSEC_IDX_FD_CONTROL) && reset_mode_ff) begin
      fd_enable_ff <= avs_writedata[`FDSEC_BIT_FDEN];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_state_ff <= FDSEC_ST_INTEGRATING;
    end else begin
      op_state_ff <= op_state;
    end
  end

  // Status flags are sticky; no software write reaches them, only reset mode does.
  genvar gi;
  generate
    for (gi = 0; gi < `FDSEC_NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          flags_ff[gi] <= 1'b0;
        end else if (reset_mode_ff) begin
          flags_ff[gi] <= 1'b0;
        end else if (fd_enable_ff && flag_evt[gi]) begin
          flags_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  fdsec_dperr_cnt u_dperr_cnt (
    .clk(clk),
    .nrst(nrst),
    .clr(reset_mode_ff),
    .inc(dp_inc),
    .count(dp_count)
  );

  assign int_evt = {dp_inc, flag_evt & {`FDSEC_NUM_FLAGS{fd_active}}};
  assign int_clr = (wr_accept && (idx == `FDSEC_IDX_INT_CLEAR)) ?
                   avs_writedata[`FDSEC_NUM_INTS-1:0] : {`FDSEC_NUM_INTS{1'b0}};

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_status_ff <= {`FDSEC_NUM_INTS{1'b0}};
    end else begin
      int_status_ff <= (int_status_ff & ~int_clr) | int_evt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_enable_ff <= {`FDSEC_NUM_INTS{1'b0}};
    end else if (wr_accept && (idx == `FDSEC_IDX_INT_ENABLE)) begin
      int_enable_ff <= avs_writedata[`FDSEC_NUM_INTS-1:0];
    end
  end

  // Registered to keep the output glitch free; it lags the status by one cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_status_ff & int_enable_ff);
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign fd_enable = fd_enable_ff;
  assign reset_mode = reset_mode_ff;
  assign irq = irq_ff;

  state_field_a: assert property (
    @(posedge clk) disable iff (!nrst)
    1'b1 |=> status_byte[`FDSEC_STATE_MSB:`FDSEC_STATE_LSB] == $past(op_state))
    else $error("State field does not follow the engine state.");

  pee_flag_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (fd_active && evt_res_recessive) |=> flags_ff[`FDSEC_BIT_PEE] ##1
    (reset_mode_ff || flags_ff[`FDSEC_BIT_PEE]))
    else $error("Protocol exception flag not set or not held.");

  classic_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (!fd_enable_ff && !reset_mode_ff) |=> $stable(flags_ff))
    else $error("Flags changed while classic format is selected.");

  stuff_flag_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (fd_active && evt_stuff_err && frame_brs) |=> flags_ff[`FDSEC_BIT_STUFF])
    else $error("Stuff error flag not set.");

  stuff_nobrs_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (!flags_ff[`FDSEC_BIT_STUFF] && !frame_brs) |=> !flags_ff[`FDSEC_BIT_STUFF])
    else $error("Stuff error flag set without rate switching.");

  crc_flag_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (fd_active && evt_crc_err) |=> flags_ff[`FDSEC_BIT_CRC])
    else $error("CRC error flag not set.");

  bit_flag_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (fd_active && evt_bit_err) |=> flags_ff[`FDSEC_BIT_BITERR])
    else $error("Bit error flag not set.");

  form_flag_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (fd_active && evt_form_err) |=> flags_ff[`FDSEC_BIT_FORM])
    else $error("Form error flag not set.");

  count_step_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (dp_inc && !reset_mode_ff && dp_count != `FDSEC_CNT_MAX) |=>
    dp_count == $past(dp_count) + 8'h01)
    else $error("Error counter did not step by one.");

  count_sat_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (dp_count == `FDSEC_CNT_MAX && !reset_mode_ff) |=> dp_count == `FDSEC_CNT_MAX)
    else $error("Error counter left its ceiling.");

  count_clear_a: assert property (
    @(posedge clk) disable iff (!nrst)
    reset_mode_ff |=> dp_count == 8'h00 && flags_ff == {`FDSEC_NUM_FLAGS{1'b0}})
    else $error("Reset mode did not clear counter and flags.");

  fden_lock_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !reset_mode_ff |=> $stable(fd_enable_ff))
    else $error("Format changed outside reset mode.");

  ro_write_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_accept && idx == `FDSEC_IDX_DP_ERRCNT && !reset_mode_ff && !dp_inc) |=>
    $stable(dp_count))
    else $error("Software write altered the error counter.");

  bus_ack_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus acknowledge not given for exactly one cycle.");

endmodule
`default_nettype wire

// File: fdsec_engine_model.sv
// Behavioural protocol engine that feeds state and error events to the FD status block.
`timescale 1ns/10ps
`default_nettype none
module fdsec_engine_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [1:0] state_cmd,
  input wire logic [31:0] rnd,
  output logic [1:0] op_state,
  output logic evt_res_recessive,
  output logic evt_stuff_err,
  output logic frame_brs,
  output logic evt_form_err,
  output logic evt_crc_err,
  output logic evt_bit_err,
  output logic evt_dp_err
);
  // Flag events are sparse so that a short burst can leave some flags clear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {op_state, evt_res_recessive, evt_stuff_err, frame_brs} <= 5'h00;
      {evt_form_err, evt_crc_err, evt_bit_err, evt_dp_err} <= 4'h0;
    end else begin
      op_state <= run ? rnd[1:0] : state_cmd;
      evt_res_recessive <= run & (rnd[4:2] == 3'h0);
      evt_stuff_err <= run & (rnd[7:5] == 3'h0);
      frame_brs <= rnd[8];
      evt_form_err <= run & (rnd[11:9] == 3'h0);
      evt_crc_err <= run & (rnd[14:12] == 3'h0);
      evt_bit_err <= run & (rnd[17:15] == 3'h0);
      evt_dp_err <= run & rnd[18];
    end
  end
endmodule
`default_nettype wire

// File: test_fdsec_top.sv
// Self-checking bench for the FD status flags, data-phase error count and their registers.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module test_fdsec_top;
  import fdsec_pkg::*;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, run, irq, fd_enable, reset_mode;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rnd;
  logic [1:0] op_state, state_cmd;
  logic evt_res_recessive, evt_stuff_err, frame_brs, evt_form_err, evt_crc_err;
  logic evt_bit_err, evt_dp_err, fd_exp, mode_exp;
  logic [4:0] flags;
  logic [7:0] cnt;
  logic [31:0] seed = 32'h00017521;
  int bad_count = 0;
  int tests_run = 0;

  fdsec_top i_fdsec_top (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .op_state, .evt_res_recessive,
    .evt_stuff_err, .frame_brs, .evt_form_err, .evt_crc_err, .evt_bit_err, .evt_dp_err,
    .fd_enable, .reset_mode, .irq);
  fdsec_engine_model i_fdsec_engine_model (.clk, .nrst, .run, .state_cmd, .rnd, .op_state,
    .evt_res_recessive, .evt_stuff_err, .frame_brs, .evt_form_err, .evt_crc_err,
    .evt_bit_err, .evt_dp_err);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  always @(posedge clk) begin
    seed = xs(seed);
    rnd <= seed;
  end

  // Reference view of the flags and the count, fed by the same events the block sees.
  always @(posedge clk) begin
    if (nrst && fd_exp && !mode_exp) begin
      flags = flags | {evt_res_recessive, evt_stuff_err & frame_brs, evt_form_err,
        evt_crc_err, evt_bit_err};
      if (evt_dp_err && cnt != 8'hff) cnt = cnt + 8'h01;
    end
    if (mode_exp) begin
      flags = 5'h00;
      cnt = 8'h00;
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    `CHK(d, e)
  endtask

  task automatic burst(input int n);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end

  initial begin
    {nrst, avs_read, avs_write, run, fd_exp, avs_address} = 13'h0000;
    {avs_writedata, state_cmd, flags, cnt, mode_exp} = {34'h0, 5'h00, 9'h001};
    avs_byteenable = 4'hf;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    `CHK(reset_mode, 1'b1)
    `CHK(fd_enable, 1'b0)
    rd_chk(8'h94, 32'h0);
    rd_chk(8'h98, 32'h0);
    wr(8'h94, 32'hff);
    wr(8'h98, 32'hff);
    wr(8'hc4, 32'h1);
    fd_exp <= 1'b1;
    @(posedge clk);
    `CHK(fd_enable, 1'b1)
    burst(20);
    rd_chk(8'h98, 32'h0);
    wr(8'hc0, 32'h0);
    mode_exp <= 1'b0;
    wr(8'hc4, 32'h0);
    @(posedge clk);
    `CHK(fd_enable, 1'b1)
    wr(8'hcc, 32'h3f);
    avs_byteenable <= 4'he;
    wr(8'hcc, 32'h00);
    avs_byteenable <= 4'hf;
    rd_chk(8'hcc, 32'h3f);
    for (int s = 0; s < 4; s++) begin
      state_cmd <= 2'(s);
      repeat (3) @(posedge clk);
      rd_chk(8'h94, {24'h0, 2'(s), 6'h00});
    end
    burst(30);
    rd_chk(8'h98, {24'h0, cnt});
    rd_chk(8'h94, {24'h0, state_cmd, 1'b0, flags});
    rd_chk(8'hc8, {26'h0, cnt != 8'h00, flags});
    `CHK(irq, 1'b1)
    wr(8'hcc, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(8'hcc, 32'h3f);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(8'hd0, 32'h3f);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rd_chk(8'hc8, 32'h0);
    burst(600);
    rd_chk(8'h98, 32'hff);
    wr(8'h98, 32'h0);
    rd_chk(8'h98, 32'hff);
    // A reset in mid-run, then a burst in classic format that must leave all flags clear.
    nrst <= 1'b0;
    fd_exp <= 1'b0;
    mode_exp <= 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK(reset_mode, 1'b1)
    `CHK(fd_enable, 1'b0)
    `CHK(irq, 1'b0)
    rd_chk(8'h98, 32'h0);
    wr(8'hc0, 32'h0);
    mode_exp <= 1'b0;
    burst(30);
    rd_chk(8'h94, {24'h0, state_cmd, 6'h00});
    rd_chk(8'h98, 32'h0);
    wr(8'hc0, 32'h1);
    mode_exp <= 1'b1;
    rd_chk(8'h98, 32'h0);
    rd_chk(8'h94, {24'h0, state_cmd, 6'h00});
    rd_chk(8'h10, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
